// ==== design/cacc_pkg.sv ====
// Package with control bit positions, reset values and widths for clamp and coast control.
package cacc_pkg;
  localparam int CTRL_ADDR_CLAMP = 8'h0f;
  localparam int CTRL_ADDR_HSYNC = 8'h0e;
  localparam int BIT_CLAMP_SEL = 7;
  localparam int BIT_CLAMP_POL = 6;
  localparam int BIT_COAST_POL = 3;
  localparam int BIT_HSYNC_POL = 6;
  localparam logic RST_CLAMP_SEL = 1'h0;
  localparam logic RST_CLAMP_POL = 1'h1;
  localparam logic RST_COAST_POL = 1'h1;
  localparam logic RST_HSYNC_POL = 1'h1;
  localparam int CNT_W = 8;
  localparam logic [7:0] RST_CLAMP_DELAY = 8'h04;
  localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
  typedef enum logic [2:0] {
    CACC_IDLE = 3'b001,
    CACC_DELAY = 3'b010,
    CACC_CLAMP = 3'b100
  } cacc_state_t;
endpackage : cacc_pkg

// ==== design/cacc_sync.sv ====
// Two-flop synchroniser for one level input.
`timescale 1ns/1ps
module cacc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= 1'h0;
      q <= 1'h0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : cacc_sync

// ==== design/cacc_clamp_and_coast_control.sv ====
// Clamp window selection, internal clamp timing and pixel-clock coast control.
// Contract
// (R1) External clamp window is used only when clamp select is 1; select resets to 0.
// (R2) With select 0, clamp is delay then duration counted after hsync trailing edge.
// (R3) Clamp polarity bit sets the active level of the external clamp window.
// (R4) Unused clamp input is tied low by the board with select kept 0.
// (R5) Source should assert external clamp only during the black back porch.
// (R6) While hold is active the clock generator freewheels instead of tracking hsync.
// (R7) Hold polarity bit sets the active level of the hold input.
// (R8) Hold polarity resets to 1.
// (R9) Unused hold input is tied so that it is never active.
// (R10) Only hsync leading edge is the reference; polarity 0 falling, 1 rising.
// (R11) Clamp window and hold inputs are synchronised before polarity is applied.
`timescale 1ns/1ps
module cacc_clamp_and_coast_control #(
  parameter int CNT_WIDTH = cacc_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsync,
  input wire logic clamp_in,
  input wire logic coast_in,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [CNT_WIDTH-1:0] cfg_clamp_delay,
  input wire logic [CNT_WIDTH-1:0] cfg_clamp_width,
  output logic clamp_out,
  output logic pll_freewheel,
  output logic hsync_lead,
  output logic clamp_sel,
  output logic clamp_pol,
  output logic coast_pol,
  output logic hsync_pol
);
  // The counter must hold a useful delay, yet stay narrow enough to close at pixel rate.
  if (CNT_WIDTH < 2 || CNT_WIDTH > 16) begin : g_bad_width
    $error("CNT_WIDTH out of range");
  end

  logic clamp_s;
  logic coast_s;
  logic hsync_s;
  logic hsync_d;
  logic lead_edge;
  logic trail_edge;
  logic clamp_ext;
  logic coast_act;
  logic clamp_int;
  logic [CNT_WIDTH-1:0] cnt;
  cacc_pkg::cacc_state_t state;

  // A pin is active when its level matches the polarity bit.
  function automatic logic apply_pol(input logic pin, input logic pol);
    return pin ~^ pol;
  endfunction : apply_pol

  // One-cycle edge of a synchronised level, rising when rise is 1.
  function automatic logic level_edge(input logic now, input logic prev, input logic rise);
    return rise ? (now & ~prev) : (~now & prev);
  endfunction : level_edge

  function automatic logic addr_hit(input logic [7:0] addr, input int target);
    return addr == 8'(target);
  endfunction : addr_hit

  // Raw pins go through synchronisers first; the pin domain is not trusted.
  cacc_sync u_sync_clamp (.ref_clk(ref_clk), .rst(rst), .d(clamp_in), .q(clamp_s)); // R11
  cacc_sync u_sync_coast (.ref_clk(ref_clk), .rst(rst), .d(coast_in), .q(coast_s)); // R11
  cacc_sync u_sync_hsync (.ref_clk(ref_clk), .rst(rst), .d(hsync), .q(hsync_s)); // R10

  // Control bits written by the configuration host.
  // Other addresses fall through untouched, so a stray write cannot flip a bit.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clamp_sel <= cacc_pkg::RST_CLAMP_SEL; // R1
      clamp_pol <= cacc_pkg::RST_CLAMP_POL;
      coast_pol <= cacc_pkg::RST_COAST_POL; // R8
      hsync_pol <= cacc_pkg::RST_HSYNC_POL;
    end else if (cfg_we) begin
      if (addr_hit(cfg_addr, cacc_pkg::CTRL_ADDR_CLAMP)) begin
        clamp_sel <= cfg_wdata[cacc_pkg::BIT_CLAMP_SEL];
        clamp_pol <= cfg_wdata[cacc_pkg::BIT_CLAMP_POL];
        coast_pol <= cfg_wdata[cacc_pkg::BIT_COAST_POL];
      end
      if (addr_hit(cfg_addr, cacc_pkg::CTRL_ADDR_HSYNC)) begin
        hsync_pol <= cfg_wdata[cacc_pkg::BIT_HSYNC_POL];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hsync_d <= 1'h0;
    end else begin
      hsync_d <= hsync_s;
    end
  end

  // Leading edge follows polarity; the trailing edge is its opposite.
  // Edges come from synchronised levels, so a pin glitch shorter than a cycle is lost unless it spans a rising clock edge.
  assign lead_edge = level_edge(hsync_s, hsync_d, hsync_pol); // R10
  assign trail_edge = level_edge(hsync_s, hsync_d, ~hsync_pol); // R2

  assign clamp_ext = apply_pol(clamp_s, clamp_pol); // R3
  assign coast_act = apply_pol(coast_s, coast_pol); // R7

  // Internal clamp timing: a zero delay goes straight to the window.
  // A trailing edge seen while a window is pending or open is dropped, not retriggered.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= cacc_pkg::CACC_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        cacc_pkg::CACC_IDLE: begin
          if (trail_edge) begin // R2
            if (cfg_clamp_delay == '0) begin
              state <= cacc_pkg::CACC_CLAMP;
              cnt <= cfg_clamp_width;
            end else begin
              state <= cacc_pkg::CACC_DELAY;
              cnt <= cfg_clamp_delay;
            end
          end
        end
        cacc_pkg::CACC_DELAY: begin
          if (cnt == CNT_WIDTH'(1)) begin
            state <= cacc_pkg::CACC_CLAMP;
            cnt <= cfg_clamp_width;
          end else begin
            cnt <= cnt - CNT_WIDTH'(1);
          end
        end
        cacc_pkg::CACC_CLAMP: begin
          if (cnt <= CNT_WIDTH'(1)) begin
            state <= cacc_pkg::CACC_IDLE;
            cnt <= '0;
          end else begin
            cnt <= cnt - CNT_WIDTH'(1);
          end
        end
      endcase
    end
  end

  // Zero width leaves the window state with a zero count, so no window is shown.
  assign clamp_int = (state == cacc_pkg::CACC_CLAMP) && (cnt != '0);

  // Outputs are registered so the analog switches see clean levels.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clamp_out <= 1'h0;
      pll_freewheel <= 1'h0;
      hsync_lead <= 1'h0;
    end else begin
      clamp_out <= clamp_sel ? clamp_ext : clamp_int; // R1 R2
      pll_freewheel <= coast_act; // R6
      // Coast masks the reference edge so the clock generator keeps its phase.
      hsync_lead <= lead_edge & ~coast_act; // R6 R10
    end
  end

  chk_ext_clamp_used: assert property (@(posedge ref_clk) disable iff (rst) // R1
    clamp_sel |=> clamp_out == $past(clamp_ext))
    else $error("external clamp not followed");
  chk_int_clamp_used: assert property (@(posedge ref_clk) disable iff (rst) // R2
    !clamp_sel |=> clamp_out == $past(clamp_int))
    else $error("internal clamp not followed");
  chk_delay_then_win: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (state == cacc_pkg::CACC_DELAY && cnt == CNT_WIDTH'(1) && cfg_clamp_width != '0)
    |=> state == cacc_pkg::CACC_CLAMP)
    else $error("delay did not enter window");
  chk_clamp_pol: assert property (@(posedge ref_clk) disable iff (rst) // R3
    (clamp_sel && $stable(clamp_sel) && clamp_s == clamp_pol) |=> clamp_out)
    else $error("clamp polarity wrong");
  chk_coast_follow: assert property (@(posedge ref_clk) disable iff (rst) // R6
    pll_freewheel |-> !hsync_lead)
    else $error("hsync tracked during coast");
  chk_coast_pol: assert property (@(posedge ref_clk) disable iff (rst) // R7
    (coast_s == coast_pol) |=> pll_freewheel)
    else $error("coast polarity wrong");
  chk_coast_reset: assert property (@(posedge ref_clk) // R8
    $fell(rst) |-> coast_pol && !clamp_sel)
    else $error("reset values wrong");
  chk_lead_edge: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (hsync_pol && hsync_s && !hsync_d && !coast_act) |=> hsync_lead)
    else $error("leading edge missed");
  chk_sync_delay: assert property (@(posedge ref_clk) disable iff (rst) // R11
    $changed(coast_s) |-> $past(coast_in, 2) == coast_s)
    else $error("sync stage skipped");

  // Edge choice, window timing, coast gating and input conditioning.
  chk_lead_fall: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (!hsync_pol && !hsync_s && hsync_d && !coast_act) |=> hsync_lead)
    else $error("falling leading edge missed");
  chk_trail_ignored: assert property (@(posedge ref_clk) disable iff (rst) // R10
    (hsync_pol && !hsync_s && hsync_d) |=> !hsync_lead)
    else $error("trailing edge used as reference");
  chk_coast_gate: assert property (@(posedge ref_clk) disable iff (rst) // R6
    coast_act |=> !hsync_lead)
    else $error("reference edge passed during coast");
  chk_trail_starts: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (state == cacc_pkg::CACC_IDLE && trail_edge) |=> state != cacc_pkg::CACC_IDLE)
    else $error("trailing edge did not start timing");
  chk_delay_holds: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (state == cacc_pkg::CACC_DELAY && cnt != CNT_WIDTH'(1)) |=> state == cacc_pkg::CACC_DELAY)
    else $error("delay cut short");
  chk_win_ends: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (state == cacc_pkg::CACC_CLAMP && cnt <= CNT_WIDTH'(1)) |=> state == cacc_pkg::CACC_IDLE)
    else $error("window did not end");
  chk_idle_no_clamp: assert property (@(posedge ref_clk) disable iff (rst) // R2
    (!clamp_sel && state != cacc_pkg::CACC_CLAMP) |=> !clamp_out)
    else $error("clamp outside internal window");
  chk_clamp_inactive: assert property (@(posedge ref_clk) disable iff (rst) // R3
    (clamp_sel && clamp_s != clamp_pol) |=> !clamp_out)
    else $error("inactive clamp level used");
  chk_coast_idle: assert property (@(posedge ref_clk) disable iff (rst) // R7
    (coast_s != coast_pol) |=> !pll_freewheel)
    else $error("inactive hold level used");
  chk_clamp_sync: assert property (@(posedge ref_clk) disable iff (rst) // R11
    $changed(clamp_s) |-> $past(clamp_in, 2) == clamp_s)
    else $error("clamp sync stage skipped");
endmodule : cacc_clamp_and_coast_control

// ==== verification/cacc_src_model.sv ====
// Behavioural sync source that sends one horizontal sync pulse on request.
`timescale 1ns/1ps
module cacc_src_model (
  input wire logic ref_clk,
  input wire logic hs_pol,
  input wire logic go,
  output logic hsync
);
  int n = 0;
  // The pulse is five cycles long so that its trailing edge lands well after the leading one.
  // Go is taken on the rising edge, so the bench's falling-edge strobe never races it.
  always @(posedge ref_clk) begin
    if (go && n == 0) begin
      n <= 1;
    end else if (n != 0) begin
      n <= (n == 5) ? 0 : n + 1;
    end
  end
  assign hsync = (n != 0) ? hs_pol : ~hs_pol;
endmodule : cacc_src_model

// ==== verification/cacc_clamp_and_coast_control_tb.sv ====
// Self-checking testbench for clamp and coast control.
`timescale 1ns/1ps
module cacc_clamp_and_coast_control_tb;
  logic ref_clk = 0, rst = 1, clamp_in = 0, coast_in = 0, cfg_we = 0, go = 0, hs_pol = 1;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
  logic [7:0] dly = 8'h04, wid = 8'h06;
  logic hsync, clamp_out, pll_freewheel, hsync_lead, clamp_sel, clamp_pol, coast_pol, hsync_pol;
  int err_count = 0, cmp_count = 0, n_clamp = 0, n_lead = 0;
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    n_clamp += clamp_out;
    n_lead += hsync_lead;
  end
  cacc_src_model cacc_src_model_i (.ref_clk(ref_clk), .hs_pol(hs_pol), .go(go), .hsync(hsync));
  cacc_clamp_and_coast_control cacc_clamp_and_coast_control_i (.ref_clk(ref_clk), .rst(rst),
    .hsync(hsync), .clamp_in(clamp_in), .coast_in(coast_in), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_clamp_delay(dly), .cfg_clamp_width(wid),
    .clamp_out(clamp_out), .pll_freewheel(pll_freewheel), .hsync_lead(hsync_lead),
    .clamp_sel(clamp_sel), .clamp_pol(clamp_pol), .coast_pol(coast_pol), .hsync_pol(hsync_pol));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cfg_we = 1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_we = 0;
    idle(4);
  endtask : wr
  task pulse;
    @(negedge ref_clk);
    n_clamp = 0;
    n_lead = 0;
    go = 1;
    @(negedge ref_clk);
    go = 0;
    idle(30);
  endtask : pulse
  task print_verdict;
    $display("cmp_count=%0d err_count=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    idle(5);
    rst = 0;
    check(clamp_sel, 0);
    check(coast_pol, 1);
    check(clamp_pol, 1);
    check(hsync_pol, 1);
    // The source holds the external window only while black level is present.
    clamp_in = 1;
    wr(8'h0f, 8'hc8);
    check(clamp_out, 1);
    wr(8'h0f, 8'h88);
    check(clamp_pol, 0);
    check(clamp_out, 0);
    clamp_in = 0;
    idle(4);
    check(clamp_out, 1);
    wr(8'h0f, 8'h08);
    check(clamp_out, 0);
    pulse();
    check(n_clamp[7:0], wid);
    check(n_lead[7:0], 1);
    hs_pol = 0;
    wr(8'h0e, 8'h00);
    // Flipping the sync sense makes one stray edge; let its window run out first.
    idle(20);
    pulse();
    check(n_lead[7:0], 1);
    check(n_clamp[7:0], wid);
    wr(8'h0d, 8'hff);
    check(hsync_pol, 0);
    check(clamp_sel, 0);
    coast_in = 1;
    idle(4);
    check(pll_freewheel, 1);
    pulse();
    check(n_lead[7:0], 0);
    check(n_clamp[7:0], wid);
    // With polarity 0 a high hold pin is the idle level of an unused input.
    wr(8'h0f, 8'h00);
    check(pll_freewheel, 0);
    rst = 1;
    idle(2);
    rst = 0;
    check(coast_pol, 1);
    check(clamp_sel, 0);
    print_verdict();
  end
endmodule : cacc_clamp_and_coast_control_tb
